// ===== chain_cfg_pkg.sv
// Constants shared by the configuration and error chain access logic.
package chain_cfg_pkg;

  // ---------------------------------------------------------------------
  // Chain geometry
  // ---------------------------------------------------------------------
  localparam int ONCE_BITS = 367;  // Bits shifted in from the boot ROM.
  localparam int ONCE_USED = 304;  // Bits actually held as configuration.
  localparam int MANY_BITS = 36;   // Rewritable chain length.
  localparam int ERR_BITS  = 60;   // Error-capture chain length.
  localparam int FIELD_W   = 6;    // Bits moved per register access.
  localparam int DATA_W    = 64;   // Internal register data width.
  localparam int CNT_W     = 9;    // Wide enough to count ONCE_BITS.

  // ---------------------------------------------------------------------
  // Register selection and field positions
  // ---------------------------------------------------------------------
  localparam logic SEL_DATA_PORT = 1'h0;  // chain_data_port.
  localparam logic SEL_SHIFT_TRIG = 1'h1; // chain_shift_trigger.
  localparam int   TRIG_BIT      = 0;     // Shift request bit.

  // ---------------------------------------------------------------------
  // Loader states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    LD_WAIT_BUILT_IN_SELF_TEST,
    LD_SHIFT,
    LD_DONE
  } load_state_t;

endpackage : chain_cfg_pkg

// ===== cache_unit_config_chains.sv
// Serial access logic for the one-time, rewritable and error-capture chains.
`timescale 1ns/100ps

module cache_unit_config_chains
  import chain_cfg_pkg::*;
#(
  parameter int ONCE_LEN  = ONCE_BITS,
  parameter int ONCE_KEEP = ONCE_USED,
  parameter int MANY_LEN  = MANY_BITS,
  parameter int ERR_LEN   = ERR_BITS
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 built_in_self_test_done,
  input  wire logic                 rom_bit_in,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic                 reg_sel,
  input  wire logic [DATA_W-1:0]    reg_wdata,
  input  wire logic                 wr_retire,
  input  wire logic                 err_capture,
  input  wire logic [ERR_LEN-1:0]   err_word,
  output logic                      rom_shift_q,
  output logic                      once_done_q,
  output logic [ONCE_KEEP-1:0]      once_cfg_q,
  output logic [MANY_LEN-1:0]       many_cfg_q,
  output logic [DATA_W-1:0]         rd_data_q,
  output logic                      rd_valid_q
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Decodes a privileged write to one of the two registers.
  function automatic logic reg_hit(input logic wr, input logic sel,
                                   input logic target);
    return wr && (sel == target);
  endfunction : reg_hit

  logic trig_wr;
  logic port_wr;
  logic shift_req;

  // Only a one in the trigger bit asks for a shift; zero writes do nothing.
  assign trig_wr   = reg_hit(reg_wr, reg_sel, SEL_SHIFT_TRIG);
  assign port_wr   = reg_hit(reg_wr, reg_sel, SEL_DATA_PORT);
  assign shift_req = trig_wr && reg_wdata[TRIG_BIT];

  // ---------------------------------------------------------------------
  // One-time chain loader
  // ---------------------------------------------------------------------
  load_state_t          ld_state_q, ld_state_d;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic [ONCE_KEEP-1:0] once_cfg_d;
  logic                 rom_shift_d;
  logic                 once_done_d;

  // Only the low ONCE_KEEP bits are stored; the early, unused bits fall out
  // of the top, so no storage is spent on them.
  always_comb begin
    ld_state_d  = ld_state_q;
    cnt_d       = cnt_q;
    once_cfg_d  = once_cfg_q;
    rom_shift_d = 1'b0;
    once_done_d = once_done_q;
    unique case (ld_state_q)
      LD_WAIT_BUILT_IN_SELF_TEST: begin
        if (built_in_self_test_done) begin
          ld_state_d  = LD_SHIFT;
          rom_shift_d = 1'b1;
          cnt_d       = '0;
        end
      end
      LD_SHIFT: begin
        once_cfg_d = {once_cfg_q[ONCE_KEEP-2:0], rom_bit_in};
        if (cnt_q == CNT_W'(ONCE_LEN - 1)) begin
          ld_state_d  = LD_DONE;
          once_done_d = 1'b1;
        end else begin
          cnt_d       = cnt_q + CNT_W'(1);
          rom_shift_d = 1'b1;
        end
      end
      LD_DONE: begin
        once_done_d = 1'b1;
      end
    endcase
  end

  // Loader registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ld_state_q  <= LD_WAIT_BUILT_IN_SELF_TEST;
      cnt_q       <= '0;
      once_cfg_q  <= '0;
      rom_shift_q <= 1'b0;
      once_done_q <= 1'b0;
    end else begin
      ld_state_q  <= ld_state_d;
      cnt_q       <= cnt_d;
      once_cfg_q  <= once_cfg_d;
      rom_shift_q <= rom_shift_d;
      once_done_q <= once_done_d;
    end
  end

  // ---------------------------------------------------------------------
  // Rewritable chain, error chain and data port
  // ---------------------------------------------------------------------
  logic [FIELD_W-1:0]  hold_q, hold_d;
  logic                pend_q, pend_d;
  logic [MANY_LEN-1:0] many_cfg_d;
  logic [ERR_LEN-1:0]  err_q, err_d;
  logic [FIELD_W-1:0]  port_q, port_d;
  logic [DATA_W-1:0]   rd_data_d;
  logic                rd_valid_d;

  // A data port write fills the holding register and port_q; the chain moves at
  // retire so that a squashed write never disturbs configuration.
  always_comb begin
    hold_d     = hold_q;
    pend_d     = pend_q;
    many_cfg_d = many_cfg_q;
    err_d      = err_q;
    port_d     = port_q;
    if (pend_q && wr_retire) begin
      many_cfg_d = {many_cfg_q[MANY_LEN-FIELD_W-1:0], hold_q};
      pend_d     = 1'b0;
    end
    if (port_wr) begin
      hold_d = reg_wdata[FIELD_W-1:0];
      port_d = reg_wdata[FIELD_W-1:0];
      pend_d = 1'b1;
    end
    // Newly captured errors win over a shift in the same cycle.
    if (err_capture) begin
      err_d = err_word;
    end else if (shift_req) begin
      err_d = {{FIELD_W{1'b0}}, err_q[ERR_LEN-1:FIELD_W]};
    end
    if (shift_req) begin
      port_d = err_q[FIELD_W-1:0];
    end
    rd_valid_d = reg_rd && (reg_sel == SEL_DATA_PORT);
    rd_data_d  = '0;
    if (rd_valid_d) begin
      rd_data_d = {{(DATA_W-FIELD_W){1'b0}}, port_q};
    end
  end

  // Chain and port registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_q     <= '0;
      pend_q     <= 1'b0;
      many_cfg_q <= '0;
      err_q      <= '0;
      port_q     <= '0;
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      hold_q     <= hold_d;
      pend_q     <= pend_d;
      many_cfg_q <= many_cfg_d;
      err_q      <= err_d;
      port_q     <= port_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Counts bits actually taken from the ROM, independent of cnt_q.
  logic [CNT_W-1:0] taken_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      taken_q <= '0;
    end else if (ld_state_q == LD_SHIFT) begin
      taken_q <= taken_q + CNT_W'(1);
    end
  end

  a_load_count: assert property ($rose(once_done_q) |-> taken_q == CNT_W'(ONCE_LEN))
    else $error("One-time chain did not take exactly the full bit count.");
  a_load_order: assert property (ld_state_q == LD_SHIFT |=>
      once_cfg_q[0] == $past(rom_bit_in) && once_cfg_q[ONCE_KEEP-1:1] ==
      $past(once_cfg_q[ONCE_KEEP-2:0]))
    else $error("One-time chain shift order is wrong.");
  a_load_wait: assert property (!built_in_self_test_done && ld_state_q == LD_WAIT_BUILT_IN_SELF_TEST |=> !rom_shift_q)
    else $error("ROM shifting began before self-test finished.");
  a_many_retire: assert property (!(pend_q && wr_retire) |=> $stable(many_cfg_q))
    else $error("Rewritable chain moved without a retiring write.");
  a_many_shift: assert property (pend_q && wr_retire |=>
      many_cfg_q[FIELD_W-1:0] == $past(hold_q))
    else $error("Held field not shifted into rewritable chain.");
  a_err_destruct: assert property (shift_req && !err_capture |=>
      err_q[ERR_LEN-1:ERR_LEN-FIELD_W] == '0 &&
      err_q[ERR_LEN-FIELD_W-1:0] == $past(err_q[ERR_LEN-1:FIELD_W]))
    else $error("Error chain not shifted by six bits.");
  a_port_load: assert property (shift_req |=> port_q == $past(err_q[FIELD_W-1:0]))
    else $error("Shifted-out error bits missing from data port.");
  a_port_read: assert property (shift_req ##1 reg_rd && reg_sel == SEL_DATA_PORT &&
      !reg_wr |=> rd_valid_q && rd_data_q[FIELD_W-1:0] == $past(port_q))
    else $error("Data port read did not return shifted-out bits.");
  a_zero_trig: assert property (trig_wr && !reg_wdata[TRIG_BIT] && !err_capture |=>
      $stable(err_q))
    else $error("Zero trigger write shifted the error chain.");
  a_reserved_zero: assert property (rd_valid_q |-> rd_data_q[DATA_W-1:FIELD_W] == '0)
    else $error("Reserved data port bits read nonzero.");

  c_load_done: cover property ($rose(once_done_q));
  c_many_write: cover property (port_wr ##[1:4] (pend_q && wr_retire));
  c_err_read: cover property (shift_req ##1 (reg_rd && reg_sel == SEL_DATA_PORT));
  c_cap_shift: cover property (err_capture && shift_req);

endmodule : cache_unit_config_chains

// ===== retire_model.sv
// Pipeline model that retires each data port write on the following cycle.
`timescale 1ns/100ps
module retire_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic reg_wr,
  input  wire logic reg_sel,
  output logic      wr_retire
);
  logic pend_q = 1'b0;
  // Retire one cycle after the write, so the held field never waits long.
  always @(posedge clk_sys) pend_q <= reg_wr && !reg_sel && !rst;
  // Driven off the sampling edge, like the rest of the bench.
  always @(negedge clk_sys) wr_retire <= pend_q;
endmodule : retire_model

// ===== cache_unit_config_chains_test.sv
// Self-checking bench for the configuration and error chain access block.
`timescale 1ns/100ps
module cache_unit_config_chains_test;
  import chain_cfg_pkg::*;
  logic                 clk_sys, rst, built_in_self_test_done, rom_bit_in, reg_wr, reg_rd, reg_sel;
  logic                 wr_retire, err_capture, rom_shift_q, once_done_q, rd_valid_q;
  logic [DATA_W-1:0]    reg_wdata, rd_data_q, d;
  logic [ERR_BITS-1:0]  err_word, err_exp;
  logic [ONCE_USED-1:0] once_cfg_q, once_exp;
  logic [MANY_BITS-1:0] many_cfg_q, many_exp;
  int                   failures, comparisons, n;
  logic [31:0]          seed = 32'h000026E8;

  cache_unit_config_chains dut (.clk_sys, .rst, .built_in_self_test_done, .rom_bit_in, .reg_wr, .reg_rd,
    .reg_sel, .reg_wdata, .wr_retire, .err_capture, .err_word, .rom_shift_q, .once_done_q,
    .once_cfg_q, .many_cfg_q, .rd_data_q, .rd_valid_q);
  retire_model partner (.clk_sys, .rst, .reg_wr, .reg_sel, .wr_retire);

  // Xorshift source, so every run sees the same data.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Wide enough for the longest chain; narrower values are zero extended.
  task automatic chk(input logic [303:0] seen, input logic [303:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // One privileged write; the strobe drops a full cycle before the next.
  task automatic wr(input logic sel, input logic [63:0] v);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = v;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  // Data port read, raised at the current falling edge so it can follow a
  // trigger write back to back; the answer stands for one cycle only, so it
  // is checked at the very next falling edge, before the strobe drops.
  task automatic rd(input logic [5:0] e);
    reg_rd = 1'b1;
    reg_sel = 1'b0;
    @(negedge clk_sys);
    chk(rd_valid_q, 1'b1);
    chk(rd_data_q, {58'h0, e});
    reg_rd = 1'b0;
  endtask : rd

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Main sequence: boot load, rewritable chain, then error read-out.
  initial begin
    {rst, built_in_self_test_done, rom_bit_in, reg_wr, reg_rd, reg_sel, err_capture} = 7'h40;
    reg_wdata = '0;
    err_word = '0;
    once_exp = '0;
    many_exp = '0;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    built_in_self_test_done = 1'b1;
    n = 0;
    // A new boot bit is offered for every cycle the loader asks for one.
    for (int i = 0; i < 400 && once_done_q !== 1'b1; i++) begin
      @(negedge clk_sys);
      if (rom_shift_q === 1'b1) begin
        rom_bit_in = ^rnd();
        once_exp = {once_exp[ONCE_USED-2:0], rom_bit_in};
        n++;
        if (n == 10) built_in_self_test_done = 1'b0;
      end
    end
    chk(n, ONCE_BITS);
    chk(once_done_q, 1'b1);
    chk(once_cfg_q, once_exp);
    $display("test boot load done");
    // Seven writes, so the oldest field is pushed out of the chain.
    for (int i = 0; i < 7; i++) begin
      d = {rnd(), rnd()};
      wr(1'b0, d);
      many_exp = {many_exp[29:0], d[5:0]};
      repeat (2) @(negedge clk_sys);
      chk(many_cfg_q, many_exp);
    end
    rd(d[5:0]);
    $display("test rewritable chain done");
    @(negedge clk_sys);
    err_exp = ERR_BITS'({rnd(), rnd()});
    err_word = err_exp;
    err_capture = 1'b1;
    @(negedge clk_sys);
    err_capture = 1'b0;
    wr(1'b1, 64'hFFFF_FFFF_FFFF_FFFE);
    // Eleven pairs: ten empty the chain, the last finds only zeros.
    for (int i = 0; i < 11; i++) begin
      wr(1'b1, {rnd(), rnd()} | 64'h1);
      rd(err_exp[5:0]);
      err_exp = err_exp >> 6;
    end
    $display("test error read-out done");
    wrap_up();
  end
endmodule : cache_unit_config_chains_test
